/* File: hw/rvi2c_target.sv */
/*
 * Write-only two-wire target holding the dual rail settings.
 * Assumes scl and sda come straight from pins, asynchronous to clk,
 * and that the pad ties the data output low and uses only its enable.
 */
`timescale 1ns/1ps
module rvi2c_target #(
    parameter rvi2c_pkg::rvi2c_variant_t VARIANT = rvi2c_pkg::RVI2C_VAR_5V0
) (
    input  wire logic                 clk,      // 20 MHz system clock
    input  wire logic                 resetn,   // Synchronous reset, low
    input  wire logic                 standby,  // Supply in standby, async
    input  wire logic                 scl_i,    // Bus clock pin level
    input  wire logic                 sda_i,    // Bus data pin level
    output logic                      sda_o,    // Data drive value
    output logic                      sda_oe,   // High while pulling data low
    output rvi2c_pkg::rvi2c_regs_t    regs_o    // Current rail settings
);
    import rvi2c_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic code_ok(input logic [4:0] c);
        code_ok = (c >= CODE_MIN) && (c <= CODE_MAX);
    endfunction

    function automatic logic [12:0] code_to_mv(input logic [4:0] c);
        logic [12:0] prod;
        prod = STEP_MV * {8'h00, c};
        code_to_mv = BASE_MV + prod;
    endfunction

    localparam logic [4:0] DEF_CODE =
        (VARIANT == RVI2C_VAR_5V4) ? DEF_CODE_5V4 : DEF_CODE_5V0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_ADDR_ACK,
        S_INDEX,
        S_INDEX_ACK,
        S_DATA,
        S_DATA_ACK,
        S_IGNORE
    } rvi2c_state_t;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0]   scl_sync_r;
    logic [1:0]   sda_sync_r;
    logic [1:0]   stby_sync_r;
    logic         scl_d_r;
    logic         sda_d_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_sync_r  <= 2'h3;
            sda_sync_r  <= 2'h3;
            stby_sync_r <= 2'h0;
            scl_d_r     <= 1'h1;
            sda_d_r     <= 1'h1;
        end else begin
            scl_sync_r  <= {scl_sync_r[0], scl_i};
            sda_sync_r  <= {sda_sync_r[0], sda_i};
            stby_sync_r <= {stby_sync_r[0], standby};
            scl_d_r     <= scl_sync_r[1];
            sda_d_r     <= sda_sync_r[1];
        end
    end

    wire scl_s     = scl_sync_r[1];
    wire sda_s     = sda_sync_r[1];
    wire stby_s    = stby_sync_r[1];
    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    // Data moving while the clock stays high marks start or stop
    wire start_c   = scl_s & scl_d_r & sda_d_r & ~sda_s;           // RULE13
    wire stop_c    = scl_s & scl_d_r & ~sda_d_r & sda_s;           // RULE14

    // ---------------------------------------------------------------
    // Receive shifter and state
    // ---------------------------------------------------------------
    rvi2c_state_t state_r;
    rvi2c_state_t state_nxt;
    logic [7:0]   shift_r;
    logic [3:0]   bit_cnt_r;
    logic [7:0]   idx_r;
    rvi2c_regs_t  regs_r;

    wire rx_state  = (state_r == S_ADDR) || (state_r == S_INDEX)
                   || (state_r == S_DATA);
    wire ack_state = (state_r == S_ADDR_ACK) || (state_r == S_INDEX_ACK)
                   || (state_r == S_DATA_ACK);
    wire byte_full = (bit_cnt_r == BYTE_BITS);
    wire byte_end  = rx_state & byte_full & scl_fall;
    wire addr_ok   = (shift_r[7:1] == TARGET_ADDR);                // RULE1
    wire dir_ok    = (shift_r[0] == DIR_WRITE);                    // RULE2
    wire wr_en     = byte_end & (state_r == S_DATA);
    wire [4:0] new_code = shift_r[CODE_MSB:0];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE:      state_nxt = S_IDLE;
            S_ADDR: begin
                if (byte_end) begin
                    state_nxt = (addr_ok && dir_ok) ? S_ADDR_ACK   // RULE2
                                                    : S_IGNORE;
                end
            end
            S_INDEX: begin
                if (byte_end) begin
                    state_nxt = S_INDEX_ACK;
                end
            end
            S_DATA: begin
                if (byte_end) begin
                    state_nxt = S_DATA_ACK;
                end
            end
            // Release after the ninth clock falls
            S_ADDR_ACK: begin
                if (scl_fall) begin
                    state_nxt = S_INDEX;                           // RULE16
                end
            end
            S_INDEX_ACK: begin
                if (scl_fall) begin
                    state_nxt = S_DATA;
                end
            end
            S_DATA_ACK: begin
                if (scl_fall) begin
                    state_nxt = S_DATA;                            // RULE17
                end
            end
            S_IGNORE:    state_nxt = S_IGNORE;
        endcase
        // Start also covers a repeated start mid-transfer
        if (start_c) begin
            state_nxt = S_ADDR;                                    // RULE13
        end
        if (stop_c) begin
            state_nxt = S_IDLE;                                    // RULE14
        end
        if (stby_s) begin
            state_nxt = S_IDLE;                                    // RULE11
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bits are taken on the rising clock, MSB first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shift_r   <= 8'h00;
            bit_cnt_r <= 4'h0;
        end else if (start_c || !rx_state) begin
            bit_cnt_r <= 4'h0;
        end else if (scl_rise && !byte_full) begin
            shift_r   <= {shift_r[6:0], sda_s};                    // RULE16
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Register index and settings
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            idx_r <= 8'h00;
        end else if (byte_end && state_r == S_INDEX) begin
            idx_r <= shift_r;
        end else if (wr_en) begin
            idx_r <= idx_r + 8'h01;                                // RULE17
        end
    end

    // Out-of-range codes keep the old value so the rail never jumps
    wire pos_wr  = wr_en & (idx_r == IDX_POS_RAIL) & code_ok(new_code); // RULE18
    wire neg_wr  = wr_en & (idx_r == IDX_NEG_RAIL) & code_ok(new_code); // RULE18
    wire mode_wr = wr_en & (idx_r == IDX_MODE);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            regs_r.positive_rail_code        <= DEF_CODE;          // RULE8
            regs_r.negative_rail_code        <= DEF_CODE;          // RULE8
            regs_r.pos_rail_discharge_select <= DEF_POS_DIS;       // RULE9
            regs_r.neg_rail_discharge_enable <= DEF_NEG_DIS;       // RULE10
            regs_r.pos_rail_mv               <= code_to_mv(DEF_CODE);
            regs_r.neg_rail_mv_mag           <= code_to_mv(DEF_CODE);
        end else begin
            if (pos_wr) begin
                regs_r.positive_rail_code <= new_code;             // RULE3
                regs_r.pos_rail_mv        <= code_to_mv(new_code); // RULE6
            end
            if (neg_wr) begin
                regs_r.negative_rail_code <= new_code;             // RULE4
                regs_r.neg_rail_mv_mag    <= code_to_mv(new_code); // RULE6
            end
            if (mode_wr) begin
                regs_r.pos_rail_discharge_select <= shift_r[POS_DIS_BIT]; // RULE5
                regs_r.neg_rail_discharge_enable <= shift_r[NEG_DIS_BIT]; // RULE5
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Open drain: only the enable moves, idle leaves the line released
    assign sda_o  = 1'h0;
    assign sda_oe = ack_state;                                     // RULE12
    assign regs_o = regs_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    stby_quiet_a: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        stby_s |=> (state_r == S_IDLE) && !sda_oe)
        else $error("interface active during standby");

    idle_release_a: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        (state_r == S_IDLE) |-> !sda_oe)
        else $error("data driven while idle");

    addr_miss_a: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        (byte_end && state_r == S_ADDR && !addr_ok && !stby_s
         && !start_c && !stop_c) |=> (state_r == S_IGNORE) && !sda_oe)
        else $error("foreign address acknowledged");

    read_refuse_a: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        (byte_end && state_r == S_ADDR && shift_r[0] && !stby_s)
        |=> !sda_oe [*2])
        else $error("read request acknowledged");

    start_seen_a: assert property (@(posedge clk) disable iff (!resetn) // RULE13
        (start_c && !stby_s) |=> (state_r == S_ADDR) && (bit_cnt_r == 4'h0))
        else $error("start not decoded");

    stop_seen_a: assert property (@(posedge clk) disable iff (!resetn) // RULE14
        stop_c |=> (state_r == S_IDLE))
        else $error("stop did not end access");

    ack_release_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        (sda_oe && scl_fall) |=> !sda_oe)
        else $error("acknowledge held past ninth clock");

    ack_hold_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        $rose(sda_oe) |-> !scl_s && $past(scl_fall))
        else $error("acknowledge not started on eighth fall");

    pos_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        pos_wr |=> regs_r.positive_rail_code == $past(shift_r[4:0])
                   && regs_r.pos_rail_mv == code_to_mv($past(shift_r[4:0])))
        else $error("positive rail code not stored");

    mode_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        mode_wr |=> regs_r.pos_rail_discharge_select == $past(shift_r[POS_DIS_BIT])
                    && regs_r.neg_rail_discharge_enable == $past(shift_r[NEG_DIS_BIT]))
        else $error("mode bits not stored");

    idx_step_a: assert property (@(posedge clk) disable iff (!resetn) // RULE17
        wr_en |=> idx_r == $past(idx_r) + 8'h01)
        else $error("index did not advance");

    dead_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE18
        (wr_en && (idx_r == 8'h02 || idx_r > IDX_MODE || !code_ok(new_code))
         && idx_r != IDX_MODE) |=> $stable(regs_r))
        else $error("ignored write changed settings");

    neg_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        neg_wr |=> regs_r.negative_rail_code == $past(shift_r[4:0])
                   && regs_r.neg_rail_mv_mag == code_to_mv($past(shift_r[4:0])))
        else $error("negative rail code not stored");

    idx_load_a: assert property (@(posedge clk) disable iff (!resetn) // RULE17
        (byte_end && state_r == S_INDEX) |=> idx_r == $past(shift_r))
        else $error("register index not loaded");

    byte_ack_a: assert property (@(posedge clk) disable iff (!resetn) // RULE16
        (byte_end && (state_r != S_ADDR || (addr_ok && dir_ok)) && !stby_s) |=> sda_oe)
        else $error("accepted byte not acknowledged");

    code_range_a: assert property (@(posedge clk) disable iff (!resetn) // RULE18
        code_ok(regs_r.positive_rail_code) && code_ok(regs_r.negative_rail_code))
        else $error("rail code left the legal range");

    reset_val_a: assert property (@(posedge clk) // RULE8
        !resetn |=> regs_r.positive_rail_code == DEF_CODE
                    && regs_r.negative_rail_code == DEF_CODE
                    && regs_r.pos_rail_discharge_select
                    && regs_r.neg_rail_discharge_enable)
        else $error("reset values wrong");

endmodule // rvi2c_target

/* File: hw/rvi2c_pkg.sv */
/*
 * Constants and types of the rail voltage two-wire write target.
 * Assumes a 20 MHz system clock and a bus clock of 400 kHz at most.
 */
// How it works
// RULE1 - Answer only target address 0111110
// RULE2 - Read direction refused, no read-back
// RULE3 - Index 0 holds positive rail code
// RULE4 - Index 1 holds negative rail code
// RULE5 - Index 3: bit1 pos select, bit0 neg enable
// RULE6 - Code n gives 4.0 V plus n*100 mV
// RULE7 - Controller never writes voltage code zero
// RULE8 - Variant default code 10 or 14
// RULE9 - Positive discharge select resets to one
// RULE10 - Negative discharge enable resets to one
// RULE11 - Standby disables the serial interface
// RULE12 - Both lines high means bus idle
// RULE13 - Data falls, clock high: start
// RULE14 - Data rises, clock high: stop
// RULE15 - Controller changes data only clock low
// RULE16 - Eight bits MSB first, ninth acknowledged
// RULE17 - Data bytes go to incrementing indices
// RULE18 - Other indices and bad codes ignored
package rvi2c_pkg;

    // ---------------------------------------------------------------
    // Bus constants
    // ---------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR  = 7'h3E;
    localparam logic       DIR_WRITE    = 1'h0;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    // ---------------------------------------------------------------
    // Register indices and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_POS_RAIL = 8'h00;
    localparam logic [7:0] IDX_NEG_RAIL = 8'h01;
    localparam logic [7:0] IDX_MODE     = 8'h03;
    localparam int         CODE_MSB     = 4;
    localparam int         POS_DIS_BIT  = 1;
    localparam int         NEG_DIS_BIT  = 0;

    // ---------------------------------------------------------------
    // Reset values and code range
    // ---------------------------------------------------------------
    localparam logic [4:0] DEF_CODE_5V0 = 5'h0A;
    localparam logic [4:0] DEF_CODE_5V4 = 5'h0E;
    localparam logic       DEF_POS_DIS  = 1'h1;
    localparam logic       DEF_NEG_DIS  = 1'h1;
    localparam logic [4:0] CODE_MIN     = 5'h01;
    localparam logic [4:0] CODE_MAX     = 5'h11;
    localparam logic [12:0] BASE_MV     = 13'hFA0;
    localparam logic [12:0] STEP_MV     = 13'h064;

    typedef enum logic {
        RVI2C_VAR_5V0,
        RVI2C_VAR_5V4
    } rvi2c_variant_t;

    // Settings seen by the analog side; rail magnitudes in millivolts
    typedef struct packed {
        logic [4:0]  positive_rail_code;
        logic [4:0]  negative_rail_code;
        logic        pos_rail_discharge_select;
        logic        neg_rail_discharge_enable;
        logic [12:0] pos_rail_mv;
        logic [12:0] neg_rail_mv_mag;
    } rvi2c_regs_t;

endpackage

/* File: bench/rvi2c_ctrl_model.sv */
/*
 * Behavioural two-wire bus controller that issues register writes.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
module rvi2c_ctrl_model (
    input  wire logic clk,      // System clock, used for pacing only
    input  wire logic sda,      // Resolved data line level
    output logic      scl,      // Bus clock, stands high after a stop
    output logic      sda_pull  // High while pulling data low
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ---------------------------------------------------------------
    // Bus phases, half period of four system cycles
    // ---------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic start();
        if (scl === 1'b0) begin
            wait_clk(2);
            sda_pull = 1'b0;
            wait_clk(2);
            scl = 1'b1;
            wait_clk(4);
        end
        sda_pull = 1'b1;
        wait_clk(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        wait_clk(2);
        sda_pull = 1'b1;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(4);
        sda_pull = 1'b0;
        wait_clk(4);
    endtask

    // Data moves mid-low so it never changes while the clock is high
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            wait_clk(2);
            sda_pull = ~b[i];
            wait_clk(2);
            scl = 1'b1;
            wait_clk(4);
            scl = 1'b0;
        end
        wait_clk(2);
        sda_pull = 1'b0;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(2);
        ack = ~sda;
        wait_clk(2);
        scl = 1'b0;
    endtask
endmodule // rvi2c_ctrl_model

/* File: bench/tb_rvi2c_target.sv */
/*
 * Self-checking bench for the rail voltage two-wire write target.
 * Assumes the controller model drives the bus; both variants share it.
 */
`timescale 1ns/1ps
module tb_rvi2c_target;
    import rvi2c_pkg::*;

    logic        clk;
    logic        resetn;
    logic        standby;
    logic        scl;
    logic        sda_pull;
    logic        sda;
    logic        sda_oe;
    logic        sda_o;
    logic        sda_oe_alt;
    rvi2c_regs_t regs;
    rvi2c_regs_t regs_alt;
    int          num_errors   = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    // Open-drain wire with pull-up
    // The drive value gates uut's pull: a high sda_o would drop it, but uut_alt still pulls the acknowledge low
    assign sda = ~(sda_pull | (sda_oe & ~sda_o) | sda_oe_alt);

    rvi2c_target uut (.clk(clk), .resetn(resetn), .standby(standby), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .regs_o(regs));
    rvi2c_target #(.VARIANT(RVI2C_VAR_5V4)) uut_alt (.clk(clk), .resetn(resetn),
        .standby(standby), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe_alt),
        .regs_o(regs_alt));
    rvi2c_ctrl_model ctl (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Checking helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [12:0] exp, input logic [12:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    function automatic logic [12:0] mv(input int c);
        return 13'(4000 + 100 * c);
    endfunction

    task automatic chk_rails(input int p, input int n);
        check("pos code", 13'(p), 13'(regs.positive_rail_code));
        check("pos mv", mv(p), regs.pos_rail_mv);
        check("neg code", 13'(n), 13'(regs.negative_rail_code));
        check("neg mv", mv(n), regs.neg_rail_mv_mag);
    endtask

    task automatic chk_mode(input logic s, input logic x);
        check("pos discharge", 13'(s), 13'(regs.pos_rail_discharge_select));
        check("neg discharge", 13'(x), 13'(regs.neg_rail_discharge_enable));
    endtask

    // Full write frame; every byte's acknowledge is compared
    task automatic wr(input logic [7:0] ab, input logic [7:0] idx, input logic [7:0] d[$],
                      input logic exp_ack, input logic do_stop);
        logic a;
        ctl.start();
        ctl.send_byte(ab, a);
        check("addr ack", 13'(exp_ack), 13'(a));
        ctl.send_byte(idx, a);
        check("index ack", 13'(exp_ack), 13'(a));
        foreach (d[i]) begin
            ctl.send_byte(d[i], a);
            check("data ack", 13'(exp_ack), 13'(a));
        end
        if (do_stop)
            ctl.stop();
    endtask

    // ---------------------------------------------------------------
    // Hang guard, well above the few thousand cycles the run needs
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            $display("[FAIL] timeout expected done seen hang");
            report_and_stop();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        resetn  = 1'b0;
        standby = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk_rails(10, 10);
        check("alt pos code", 13'(14), 13'(regs_alt.positive_rail_code));
        check("alt neg mv", mv(14), regs_alt.neg_rail_mv_mag);
        chk_mode(1'b1, 1'b1);
        wr(8'h7C, 8'h00, '{8'h0C, 8'h11}, 1'b1, 1'b1);
        chk_rails(12, 17);
        check("idle drive", 13'(0), 13'(sda_oe));
        wr(8'h7C, 8'h03, '{8'h00}, 1'b1, 1'b1);
        chk_mode(1'b0, 1'b0);
        wr(8'h7C, 8'h03, '{8'h02}, 1'b1, 1'b1);
        chk_mode(1'b1, 1'b0);
        // Code 0, code 18 and index 2 all acked but inert
        wr(8'h7C, 8'h00, '{8'h00, 8'h12, 8'hFF}, 1'b1, 1'b1);
        wr(8'h7C, 8'h04, '{8'h00}, 1'b1, 1'b1);
        chk_rails(12, 17);
        chk_mode(1'b1, 1'b0);
        wr(8'h7E, 8'h00, '{8'h05}, 1'b0, 1'b1);
        wr(8'h7D, 8'h00, '{8'h05}, 1'b0, 1'b1);
        chk_rails(12, 17);
        standby = 1'b1;
        repeat (4) @(negedge clk);
        wr(8'h7C, 8'h00, '{8'h05}, 1'b0, 1'b1);
        standby = 1'b0;
        repeat (4) @(negedge clk);
        chk_rails(12, 17);
        // Repeated start without a stop in between
        wr(8'h7C, 8'h00, '{8'h05}, 1'b1, 1'b0);
        wr(8'h7C, 8'h01, '{8'h06}, 1'b1, 1'b1);
        chk_rails(5, 6);
        check("idle drive", 13'(0), 13'(sda_oe));
        report_and_stop();
    end
endmodule // tb_rvi2c_target
